// File: adcc_top.sv
module adcc_top (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // avalon-mm slave
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // trigger sources, bit 0 unused
  input  wire logic [7:0]  trig_src,
  // analog pins, digital side
  input  wire logic [5:0]  pin_raw,
  output logic      [5:0]  pin_buf_off,
  // analog sampling core
  output logic             core_power,
  output logic             core_start,
  output logic      [3:0]  core_chan,
  output logic             core_temp,
  output logic             core_diff,
  output logic             core_gain20,
  output logic      [1:0]  core_pos,
  output logic      [1:0]  core_neg,
  output logic      [1:0]  core_ref,
  input  wire logic [9:0]  core_value
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    adcc_pkg::adcc_state_e st;
    logic [4:0]            cnt;
    logic                  first;
    logic                  en;
    logic                  sc;
    logic                  ate;
    logic                  flag;
    logic [2:0]            psel;
    logic [2:0]            tsel;
    logic                  lar;
    logic [3:0]            chan;
    logic [2:0]            refs;
    logic [3:0]            act_chan;
    logic [2:0]            act_ref;
    logic [5:0]            didr;
    logic [9:0]            res;
    logic                  lock;
    logic                  trig_q;
    logic                  resp;
    logic [7:0]            rdata;
    logic                  start;
    adcc_pkg::adcc_chan_s  dec;
    logic [1:0]            ref_src;
  } adcc_top_s;

  localparam adcc_top_s TOP_RST = '{st: adcc_pkg::ADCC_IDLE, first: 1'b1, default: '0};

  adcc_top_s   r_r;
  adcc_top_s   r_nxt;
  logic        acc;
  logic        take;
  logic        wr;
  logic        wr_a;
  logic        start_req;
  logic        trig_lvl;
  logic        trig_edge;
  logic        done;
  logic        free_run;
  logic        clr_presc;
  logic [4:0]  len;
  logic [7:0]  rd_mux;
  logic [5:0]  pin_read;

  adcc_presc_if pif ();

  adcc_presc u_presc (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pif     (pif)
  );

  adcc_pin_in #(
    .W (adcc_pkg::PIN_W)
  ) u_pin (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .pin_raw  (pin_raw),
    .mask     (r_r.didr),
    .pin_read (pin_read)
  );

  assign pif.run = r_r.en;
  assign pif.clr = clr_presc;
  assign pif.sel = r_r.psel;

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb
  begin
    case (address)
      adcc_pkg::OFS_CTRL_A:   rd_mux = {r_r.en, r_r.sc, r_r.ate, r_r.flag, 1'b0, r_r.psel};
      adcc_pkg::OFS_CTRL_B:   rd_mux = {5'h00, r_r.tsel};
      adcc_pkg::OFS_CHAN_REF: rd_mux = {r_r.refs[1:0], r_r.lar, r_r.refs[2], r_r.chan};
      adcc_pkg::OFS_RES_LOW:  rd_mux = r_r.lar ? {r_r.res[1:0], 6'h00} : r_r.res[7:0];
      adcc_pkg::OFS_RES_HIGH: rd_mux = r_r.lar ? r_r.res[9:2] : {6'h00, r_r.res[9:8]};
      adcc_pkg::OFS_PIN_DIS:  rd_mux = {2'h0, r_r.didr};
      adcc_pkg::OFS_PIN_READ: rd_mux = {2'h0, pin_read};
      default:                rd_mux = 8'h00;
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb
  begin
    r_nxt     = r_r;
    r_nxt.start = 1'b0;
    clr_presc = 1'b0;
    acc       = read || write;
    take      = acc && r_r.resp;
    r_nxt.resp = acc && !r_r.resp;
    wr        = take && write && byteenable[0];
    wr_a      = wr && (address == adcc_pkg::OFS_CTRL_A);
    start_req = wr_a && writedata[adcc_pkg::CA_SC] && writedata[adcc_pkg::CA_EN];
    free_run  = r_r.ate && (r_r.tsel == adcc_pkg::TSEL_FREE);
    trig_lvl  = (r_r.tsel != adcc_pkg::TSEL_FREE) && trig_src[r_r.tsel];
    // edge detect only, a level held high starts nothing
    trig_edge = trig_lvl && !r_r.trig_q;
    r_nxt.trig_q = trig_lvl;
    len  = r_r.first ? adcc_pkg::CONV_LEN_FIRST : adcc_pkg::CONV_LEN_NORMAL;
    done = (r_r.st == adcc_pkg::ADCC_CONV) && pif.tick && (r_r.cnt == len - 5'h01);

    if (acc && !r_r.resp)
    begin
      r_nxt.rdata = rd_mux;
    end

    if (take && read && (address == adcc_pkg::OFS_RES_LOW))
    begin
      r_nxt.lock = 1'b1;
    end
    if (take && read && (address == adcc_pkg::OFS_RES_HIGH))
    begin
      r_nxt.lock = 1'b0;
    end

    if (wr_a)
    begin
      r_nxt.en   = writedata[adcc_pkg::CA_EN];
      r_nxt.ate  = writedata[adcc_pkg::CA_ATE];
      r_nxt.psel = writedata[adcc_pkg::CA_PSEL +: 3];
      if (writedata[adcc_pkg::CA_FLAG])
      begin
        r_nxt.flag = 1'b0;
      end
    end
    if (wr && (address == adcc_pkg::OFS_CTRL_B))
    begin
      r_nxt.tsel = writedata[adcc_pkg::CB_TSEL +: 3];
    end
    if (wr && (address == adcc_pkg::OFS_CHAN_REF))
    begin
      r_nxt.chan = writedata[adcc_pkg::CR_CHAN +: 4];
      r_nxt.lar  = writedata[adcc_pkg::CR_LAR];
      r_nxt.refs = {writedata[adcc_pkg::CR_REF2], writedata[adcc_pkg::CR_REF_HI +: 2]};
    end
    if (wr && (address == adcc_pkg::OFS_PIN_DIS))
    begin
      r_nxt.didr = writedata[5:0];
    end

    // selections pass only while enabled; frozen in a conversion until it ends
    if (r_r.en && ((r_r.st != adcc_pkg::ADCC_CONV) || done))
    begin
      r_nxt.act_chan = r_r.chan;
      r_nxt.act_ref  = r_r.refs;
    end
    r_nxt.dec     = adcc_pkg::adcc_chan_dec(r_nxt.act_chan);
    r_nxt.ref_src = adcc_pkg::adcc_ref_dec(r_nxt.act_ref);

    case (r_r.st)
      adcc_pkg::ADCC_IDLE:
      begin
        // software start, also under auto trigger
        if (start_req)
        begin
          r_nxt.sc = 1'b1;
          r_nxt.st = adcc_pkg::ADCC_ARM;
        end
        // trigger edge resets prescaler and starts
        else if (r_r.ate && r_r.en && trig_edge)
        begin
          clr_presc   = 1'b1;
          r_nxt.sc    = 1'b1;
          r_nxt.cnt   = 5'h00;
          r_nxt.start = 1'b1;
          r_nxt.st    = adcc_pkg::ADCC_CONV;
        end
      end
      adcc_pkg::ADCC_ARM:
      begin
        // start waits for the next converter clock
        if (pif.tick)
        begin
          r_nxt.cnt   = 5'h00;
          r_nxt.start = 1'b1;
          r_nxt.st    = adcc_pkg::ADCC_CONV;
        end
      end
      adcc_pkg::ADCC_CONV:
      begin
        // trigger edges not looked at here
        if (done)
        begin
          if (!r_nxt.lock)
          begin
            r_nxt.res = core_value;
          end
          // flag set wins over a clear
          r_nxt.flag  = 1'b1;
          r_nxt.first = 1'b0;
          r_nxt.cnt   = 5'h00;
          // done flag as trigger restarts at once
          if (free_run)
          begin
            r_nxt.start = 1'b1;
          end
          else
          begin
            r_nxt.sc = 1'b0;
            r_nxt.st = adcc_pkg::ADCC_IDLE;
          end
        end
        else if (pif.tick)
        begin
          r_nxt.cnt = r_r.cnt + 5'h01;
        end
      end
      default:
      begin
        r_nxt.st = adcc_pkg::ADCC_IDLE;
      end
    endcase

    // switching off aborts and rearms the long first conversion
    if (!r_nxt.en)
    begin
      r_nxt.st    = adcc_pkg::ADCC_IDLE;
      r_nxt.sc    = 1'b0;
      r_nxt.cnt   = 5'h00;
      r_nxt.first = 1'b1;
      r_nxt.start = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r_r <= TOP_RST;
    else
      r_r <= r_nxt;
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign waitrequest = acc && !r_r.resp;
  assign readdata    = {24'h00_0000, r_r.rdata};
  assign pin_buf_off = r_r.didr;
  assign core_power  = r_r.en;
  assign core_start  = r_r.start;
  assign core_chan   = r_r.act_chan;
  assign core_temp   = r_r.dec.temp;
  assign core_diff   = r_r.dec.diff;
  assign core_gain20 = r_r.dec.gain20;
  assign core_pos    = r_r.dec.pos;
  assign core_neg    = r_r.dec.neg;
  assign core_ref    = r_r.ref_src;

  // ****************************************************************
  // checks
  // ****************************************************************
  logic [4:0] ticks_seen;
  always_ff @(posedge clk)
  begin
    if (sys_rst || r_r.start)
      ticks_seen <= 5'h00;
    else if (pif.tick && (r_r.st == adcc_pkg::ADCC_CONV))
      ticks_seen <= ticks_seen + 5'h01;
  end

  AST_LEN: assert property (@(posedge clk) disable iff (sys_rst)
    done |-> (ticks_seen == (r_r.first ? 5'h18 : 5'h0C))) else $error("wrong length");
  AST_LOCK_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (done && r_r.lock && !(take && read && address == adcc_pkg::OFS_RES_HIGH))
    |=> $stable(r_r.res)) else $error("result updated while blocked");
  AST_UNLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    (take && read && address == adcc_pkg::OFS_RES_HIGH) |=> !r_r.lock)
    else $error("high read did not unblock");
  AST_FLAG_SET: assert property (@(posedge clk) disable iff (sys_rst)
    (done && r_r.en && !(wr_a && !writedata[adcc_pkg::CA_EN])) |=> r_r.flag)
    else $error("flag not set at completion");
  AST_SC_CLEAR: assert property (@(posedge clk) disable iff (sys_rst)
    (done && !free_run) |=> (!r_r.sc && r_r.st == adcc_pkg::ADCC_IDLE))
    else $error("start bit not cleared");
  AST_SC_BUSY: assert property (@(posedge clk) disable iff (sys_rst)
    (r_r.st != adcc_pkg::ADCC_IDLE) |-> r_r.sc) else $error("start bit low in conversion");
  AST_CHAN_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    (r_r.st == adcc_pkg::ADCC_CONV && !done) |=> $stable(r_r.act_chan))
    else $error("channel changed in conversion");
  AST_OFF_HOLD: assert property (@(posedge clk) disable iff (sys_rst)
    !r_r.en |=> $stable(r_r.act_ref) && $stable(r_r.act_chan))
    else $error("selection applied while off");
  AST_TRIG_START: assert property (@(posedge clk) disable iff (sys_rst)
    (r_r.st == adcc_pkg::ADCC_IDLE && !start_req && r_r.ate && r_r.en && trig_edge
     && !(wr_a && !writedata[adcc_pkg::CA_EN]))
    |=> (r_r.st == adcc_pkg::ADCC_CONV && r_r.start)) else $error("trigger did not start");
  AST_BUSY_IGNORE: assert property (@(posedge clk) disable iff (sys_rst)
    (r_r.st == adcc_pkg::ADCC_CONV && trig_edge && !done && r_r.en && !r_r.start)
    |=> !r_r.start) else $error("edge restarted a busy conversion");
  AST_FREE_RUN: assert property (@(posedge clk) disable iff (sys_rst)
    (done && free_run && r_r.en && !wr_a) |=> (r_r.start && r_r.sc))
    else $error("free running did not restart");

  COV_FREE: cover property (@(posedge clk) disable iff (sys_rst) done && free_run);
  COV_DROP: cover property (@(posedge clk) disable iff (sys_rst) done && r_r.lock);
  COV_TRIG: cover property (@(posedge clk) disable iff (sys_rst)
    r_r.st == adcc_pkg::ADCC_IDLE && r_r.ate && r_r.en && trig_edge);
  COV_FIRST: cover property (@(posedge clk) disable iff (sys_rst) done && r_r.first);

endmodule : adcc_top

// File: adcc_pkg.sv
// ****************************************************************
// ****************************************************************
package adcc_pkg;

  // ****************************************************************
  // register map, byte addresses
  // ****************************************************************
  localparam logic [4:0] OFS_CTRL_A   = 5'h00;
  localparam logic [4:0] OFS_CTRL_B   = 5'h04;
  localparam logic [4:0] OFS_CHAN_REF = 5'h08;
  localparam logic [4:0] OFS_RES_LOW  = 5'h0C;
  localparam logic [4:0] OFS_RES_HIGH = 5'h10;
  localparam logic [4:0] OFS_PIN_DIS  = 5'h14;
  localparam logic [4:0] OFS_PIN_READ = 5'h18;

  // conv_control_a fields
  localparam int CA_EN   = 7;
  localparam int CA_SC   = 6;
  localparam int CA_ATE  = 5;
  localparam int CA_FLAG = 4;
  localparam int CA_PSEL = 0;
  // conv_control_b fields
  localparam int CB_TSEL = 0;
  // channel_ref_select_reg fields
  localparam int CR_REF_HI = 6;
  localparam int CR_LAR    = 5;
  localparam int CR_REF2   = 4;
  localparam int CR_CHAN   = 0;

  localparam logic [5:0] PIN_DIS_RST = 6'h00;
  localparam int         PIN_W       = 6;

  // conversion lengths in converter clocks
  localparam logic [4:0] CONV_LEN_NORMAL = 5'h0D;
  localparam logic [4:0] CONV_LEN_FIRST  = 5'h19;

  localparam logic [2:0] TSEL_FREE = 3'h0;
  localparam logic [3:0] CHAN_TEMP = 4'hF;

  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT    = 2'h1;
  localparam logic [1:0] REF_INT11  = 2'h2;
  localparam logic [1:0] REF_INT256 = 2'h3;

  typedef enum logic [2:0] {
    ADCC_IDLE = 3'b001,
    ADCC_ARM  = 3'b010,
    ADCC_CONV = 3'b100
  } adcc_state_e;

  typedef struct packed {
    logic       temp;
    logic       diff;
    logic       gain20;
    logic [1:0] pos;
    logic [1:0] neg;
  } adcc_chan_s;

  // codes 0..3 single ended, 15 temperature; codes 4..14 differential, bit3 picks positive pin 2 or 0
  function automatic adcc_chan_s adcc_chan_dec(input logic [3:0] c);
    adcc_chan_s d;
    d.temp   = (c == CHAN_TEMP);
    d.diff   = (c[3:2] != 2'h0) && (c != CHAN_TEMP);
    d.gain20 = d.diff && c[2];
    d.pos    = d.diff ? {c[3], 1'b0} : c[1:0];
    d.neg    = d.diff ? c[1:0] : 2'h0;
    return d;
  endfunction : adcc_chan_dec

  function automatic logic [1:0] adcc_ref_dec(input logic [2:0] r);
    case (r)
      3'h1:    return REF_EXT;
      3'h2:    return REF_INT11;
      3'h6:    return REF_INT256;
      3'h7:    return REF_INT256;
      default: return REF_SUPPLY;
    endcase
  endfunction : adcc_ref_dec

endpackage : adcc_pkg

// File: adcc_presc_if.sv
interface adcc_presc_if;
  logic       run;
  logic       clr;
  logic [2:0] sel;
  logic       tick;
  modport ctl (output run, output clr, output sel, input tick);
  modport div (input run, input clr, input sel, output tick);
endinterface : adcc_presc_if

// File: adcc_presc.sv
// divides clk by 2**sel (sel 0 acts as 1) and emits a one-cycle tick
module adcc_presc (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  adcc_presc_if.div pif
);
  typedef struct packed {
    logic [6:0] cnt;
  } adcc_presc_s;

  adcc_presc_s r_r;
  adcc_presc_s r_nxt;
  logic [6:0]  limit;

  always_comb
  begin
    r_nxt = r_r;
    limit = 7'((8'h01 << ((pif.sel == 3'h0) ? 3'h1 : pif.sel)) - 8'h01);
    pif.tick = pif.run && !pif.clr && (r_r.cnt == limit);
    if (!pif.run || pif.clr || pif.tick)
    begin
      r_nxt.cnt = 7'h00;
    end
    else
    begin
      r_nxt.cnt = r_r.cnt + 7'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  AST_PRESC_OFF: assert property (@(posedge clk) disable iff (sys_rst)
    !pif.run |-> !pif.tick) else $error("prescaler ticked while off");

endmodule : adcc_presc

// File: adcc_pin_in.sv
// pins come from outside the clock domain: two flops before use
module adcc_pin_in #(
  parameter int W = 6
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // pins and mask
  input  wire logic [W-1:0] pin_raw,
  input  wire logic [W-1:0] mask,
  // port value
  output logic      [W-1:0] pin_read
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] val;
  } adcc_pin_s;

  adcc_pin_s r_r;
  adcc_pin_s r_nxt;

  always_comb
  begin
    r_nxt    = r_r;
    r_nxt.s1 = pin_raw;
    r_nxt.s2 = r_r.s1;
    r_nxt.val = r_r.s2 & ~mask;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      r_r <= '0;
    else
      r_r <= r_nxt;
  end

  assign pin_read = r_r.val;

  AST_PIN_ZERO: assert property (@(posedge clk) disable iff (sys_rst)
    ##1 ((pin_read & $past(mask)) == '0)) else $error("disabled pin read nonzero");

endmodule : adcc_pin_in

// File: adcc_core_model.sv
// ****************************************************************
// analog sampling core stand-in
// ****************************************************************
module adcc_core_model (
  // clock
  input  wire logic       clk,
  // conversion handshake
  input  wire logic       core_start,
  input  wire logic [3:0] core_chan,
  output logic      [9:0] core_value,
  // statistics
  output int              n_starts
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    core_value = 10'h000;
    n_starts   = 0;
  end
  // value follows the channel on every clock
  // a channel that moves during a conversion therefore shows up in the result
  always @(posedge clk)
  begin
    core_value <= {core_chan[1:0], ~core_chan, core_chan};
    if (core_start === 1'b1)
    begin
      n_starts <= n_starts + 1;
    end
  end
endmodule : adcc_core_model

// File: adcc_top_tb_top.sv
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module adcc_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************************************
  // harness
  // ****************************************************************
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic [4:0]  address = 5'h00;
  logic        read = 1'b0;
  logic        write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [7:0]  trig_src = 8'h00;
  logic [5:0]  pin_raw = 6'h00;
  logic [5:0]  pin_buf_off;
  logic        core_start, core_temp, core_power, core_diff, core_gain20;
  logic [3:0]  core_chan;
  logic [1:0]  core_ref, core_pos, core_neg;
  logic [9:0]  core_value;
  logic [7:0]  q;
  int          fail_count = 0;
  int          n_tests = 0;
  int          cyc = 0;
  int          starts;
  int          s0;
  always #25 clk = ~clk;
  adcc_top u_dut (.clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'h1), .readdata(readdata),
    .waitrequest(waitrequest), .trig_src(trig_src), .pin_raw(pin_raw),
    .pin_buf_off(pin_buf_off), .core_power(core_power), .core_start(core_start),
    .core_chan(core_chan), .core_temp(core_temp), .core_diff(core_diff),
    .core_gain20(core_gain20), .core_pos(core_pos), .core_neg(core_neg),
    .core_ref(core_ref), .core_value(core_value));
  adcc_core_model u_core (.clk(clk), .core_start(core_start), .core_chan(core_chan),
    .core_value(core_value), .n_starts(starts));
  function automatic logic [9:0] cv(input logic [3:0] c);
    return {c[1:0], ~c, c};
  endfunction : cv
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  // one avalon transfer; request held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                     output logic [7:0] r);
    @(posedge clk);
    address   <= a;
    read      <= ~w;
    write     <= w;
    writedata <= {24'h00_0000, d};
    @(posedge clk);
    while (waitrequest !== 1'b0)
      @(posedge clk);
    r = readdata[7:0];
    read  <= 1'b0;
    write <= 1'b0;
  endtask : acc
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [7:0] dummy;
    acc(1'b1, a, d, dummy);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] r);
    acc(1'b0, a, 8'h00, r);
  endtask : rd
  // polls control register until the given bit reaches the level
  task automatic wait_bit(input int b, input logic lv);
    rd(adcc_pkg::OFS_CTRL_A, q);
    for (int i = 0; i < 100 && q[b] !== lv; i++)
      rd(adcc_pkg::OFS_CTRL_A, q);
  endtask : wait_bit
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(adcc_pkg::OFS_PIN_DIS, q); `CHK("dis_rst", 8'h00, q)
    wr(adcc_pkg::OFS_PIN_DIS, 8'hFF);
    pin_raw <= 6'h3F;
    rd(adcc_pkg::OFS_PIN_DIS, q); `CHK("dis_rw", 8'h3F, q)
    `CHK("buf_off", 6'h3F, pin_buf_off)
    rd(adcc_pkg::OFS_PIN_READ, q); `CHK("pin_all_off", 8'h00, q)
    wr(adcc_pkg::OFS_PIN_DIS, 8'h05);
    repeat (4) @(posedge clk);
    rd(adcc_pkg::OFS_PIN_READ, q); `CHK("pin_some_off", 8'h3A, q)
    rd(5'h1C, q); `CHK("unmapped", 8'h00, q)
    // single conversion, first after enable, right aligned
    wr(adcc_pkg::OFS_CHAN_REF, 8'h43);
    repeat (3) @(posedge clk);
    `CHK("chan_off", 4'h0, core_chan)
    `CHK("ref_off", adcc_pkg::REF_SUPPLY, core_ref)
    `CHK("power_off", 1'b0, core_power)
    wr(adcc_pkg::OFS_CTRL_A, 8'hC1);
    rd(adcc_pkg::OFS_CTRL_A, q); `CHK("sc_busy", 1'b1, q[6])
    `CHK("power_on", 1'b1, core_power)
    `CHK("ref_on", adcc_pkg::REF_EXT, core_ref)
    wait_bit(6, 1'b0);
    `CHK("flag", 1'b1, q[4])
    rd(adcc_pkg::OFS_RES_LOW, q); `CHK("lo_r", cv(4'h3) & 10'h0FF, {2'b00, q})
    rd(adcc_pkg::OFS_RES_HIGH, q); `CHK("hi_r", {6'h00, cv(4'h3) >> 8}, q)
    `CHK("n_start", 1, starts)
    // channel written mid-conversion applies afterwards
    wr(adcc_pkg::OFS_CHAN_REF, 8'h01);
    wr(adcc_pkg::OFS_CTRL_A, 8'hD1);
    wr(adcc_pkg::OFS_CHAN_REF, 8'h02);
    wait_bit(6, 1'b0);
    `CHK("chan_new", 4'h2, core_chan)
    // low read locks, next result dropped, flag still raised
    rd(adcc_pkg::OFS_RES_LOW, q); `CHK("lo_old", cv(4'h1) & 10'h0FF, {2'b00, q})
    wr(adcc_pkg::OFS_CTRL_A, 8'hD1);
    wait_bit(6, 1'b0);
    `CHK("flag_lost", 1'b1, q[4])
    rd(adcc_pkg::OFS_RES_HIGH, q); `CHK("hi_lock", {6'h00, cv(4'h1) >> 8}, q)
    // unlocked again, left aligned
    wr(adcc_pkg::OFS_CHAN_REF, 8'h22);
    wr(adcc_pkg::OFS_CTRL_A, 8'hD1);
    wait_bit(6, 1'b0);
    rd(adcc_pkg::OFS_RES_LOW, q); `CHK("lo_l", {cv(4'h2) & 10'h003, 6'h00}, {2'b00, q})
    rd(adcc_pkg::OFS_RES_HIGH, q); `CHK("hi_l", cv(4'h2) >> 2, {2'b00, q})
    `CHK("ref_sup", adcc_pkg::REF_SUPPLY, core_ref)
    // temperature channel and references
    wr(adcc_pkg::OFS_CHAN_REF, 8'h9F);
    repeat (3) @(posedge clk);
    `CHK("temp", 1'b1, core_temp)
    `CHK("ref256", adcc_pkg::REF_INT256, core_ref)
    wr(adcc_pkg::OFS_CHAN_REF, 8'h41);
    repeat (3) @(posedge clk);
    `CHK("ref_ext", adcc_pkg::REF_EXT, core_ref)
    `CHK("chan1", 4'h1, core_chan)
    `CHK("single", 1'b0, core_diff)
    `CHK("pos1", 2'h1, core_pos)
    `CHK("temp_off", 1'b0, core_temp)
    wr(adcc_pkg::OFS_CHAN_REF, 8'h8D);
    repeat (3) @(posedge clk);
    `CHK("ref11", adcc_pkg::REF_INT11, core_ref)
    `CHK("diff", 1'b1, core_diff)
    `CHK("gain20", 1'b1, core_gain20)
    `CHK("pos2", 2'h2, core_pos)
    `CHK("neg1", 2'h1, core_neg)
    // auto trigger: one start per fresh edge, busy edges and held level ignored
    wr(adcc_pkg::OFS_CTRL_B, 8'h02);
    wr(adcc_pkg::OFS_CTRL_A, 8'hB1);
    s0 = starts;
    trig_src <= 8'h04;
    repeat (4) @(posedge clk);
    trig_src <= 8'h00;
    repeat (2) @(posedge clk);
    trig_src <= 8'h04;
    wait_bit(4, 1'b1);
    repeat (60) @(posedge clk);
    `CHK("trig_once", s0 + 1, starts)
    trig_src <= 8'h00;
    // free run on own flag, flag left set
    wr(adcc_pkg::OFS_CTRL_B, 8'h00);
    wr(adcc_pkg::OFS_CTRL_A, 8'hE1);
    s0 = starts;
    repeat (100) @(posedge clk);
    wr(adcc_pkg::OFS_CHAN_REF, 8'h02);
    repeat (100) @(posedge clk);
    `CHK("free_run", 1'b1, (starts - s0) >= 5)
    rd(adcc_pkg::OFS_CTRL_A, q); `CHK("sc_free", 1'b1, q[6])
    rd(adcc_pkg::OFS_RES_LOW, q); `CHK("free_lo", cv(4'h2) & 10'h0FF, {2'b00, q})
    rd(adcc_pkg::OFS_RES_HIGH, q); `CHK("free_hi", {6'h00, cv(4'h2) >> 8}, q)
    wr(adcc_pkg::OFS_CTRL_A, 8'h00);
    @(posedge clk);
    `CHK("power_down", 1'b0, core_power)
    finish_test();
  end
endmodule : adcc_top_tb_top
